// ### verilog/tmr_consts.svh
// timing counts, register offsets, field positions and reset values
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define OFS_CTRL      8'h00
`define OFS_CTRL2     8'h04
`define OFS_COUNT     8'h08
`define OFS_MATCH     8'h0c
`define OFS_RELOAD    8'h10
`define OFS_DEADBAND  8'h14
`define CTRL_EN_BIT   7
`define CTRL_POL_BIT  6
`define CTRL_PRE_LSB  3
`define CTRL_MODE_LSB 0
`define CTRL2_MHI_BIT 0
`define CTRL2_OEN_BIT 1
`define COUNT_RELOAD  16'h0001
`define COUNT_RST     16'h0000
`define RELOAD_RST    16'hffff
`define DB_MAX        8'd128
`endif

// ### verilog/tmr_pkg.sv
// types shared by the timer files
package tmr_pkg;
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_CMP_COUNT,
    MODE_PWM_SINGLE,
    MODE_PWM_DUAL
  } tmr_mode_e;

  // wishbone classic slave request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  // pin-side outputs
  typedef struct packed {
    logic out;
    logic out_oe;
    logic comp;
    logic comp_oe;
  } tmr_pins_s;
endpackage

// ### verilog/tmr_prescaler.sv
// prescaler: one-cycle tick every 2^sel system clocks
`timescale 1ns/1ps
module tmr_prescaler #(
  parameter int SEL_W = 3
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             run_i,
  input  wire logic [SEL_W-1:0] sel_i,
  output logic                  tick_o
);
  initial begin
    if (SEL_W != 3) $error("prescaler select must be 3 bits");
  end

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic [6:0] lim;

  // limit is 2^sel - 1, so divide ranges over 1 to 128
  always_comb begin
    lim     = 7'((8'd1 << sel_i) - 8'd1);
    cnt_nxt = cnt_r;
    tick_o  = 1'b0;
    if (!run_i) begin
      cnt_nxt = 7'h00;
    end else if (cnt_r >= lim) begin
      cnt_nxt = 7'h00;
      tick_o  = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 7'h01;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) cnt_r <= 7'h00;
    else          cnt_r <= cnt_nxt;
  end
endmodule // tmr_prescaler

// ### verilog/tmr_deadband.sv
// dead band: delays each rising edge of a level by db_i clocks
`timescale 1ns/1ps
module tmr_deadband (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       lvl_i,
  input  wire logic [7:0] db_i,
  output logic            lvl_o
);
  logic       out_r;
  logic       out_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;

  // falls follow at once; rises wait db_i cycles of steady high input
  always_comb begin
    out_nxt = out_r;
    cnt_nxt = cnt_r;
    if (!lvl_i) begin
      out_nxt = 1'b0;
      cnt_nxt = 8'h00;
    end else if (!out_r) begin
      // count the edge that sets out_r, so a rise lands db_i clocks late
      if (cnt_r + 8'h01 >= db_i) begin
        out_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      out_r <= 1'b0;
      cnt_r <= 8'h00;
    end else begin
      out_r <= out_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // zero delay passes the level combinationally, same edge as source
  // falls pass at once, so the partner's delayed rise leaves a gap
  assign lvl_o = lvl_i & ((db_i == 8'h00) | out_r);
endmodule // tmr_deadband

// ### verilog/timer_pwm_comparator_counter.sv
// top: 16-bit reload timer, comparator counter and pwm modes, wb slave
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tmr_consts.svh"
// Contract
// - comparator mode counts comparator edges; polarity bit picks rising or falling.
// - comparator mode bypasses prescaler; each qualifying edge adds exactly one.
// - comparator mode: at reload value raise interrupt, load 0001h, continue.
// - comparator mode: toggle timer output at each reload when output enabled.
// - comparator mode: polarity bit sets initial output level, enabled or not.
// - comparator mode: written start count used first pass only, then 0001h.
// - pwm modes count prescaled clock, toggle output on match value.
// - pwm modes: continue to reload, raise interrupt, load 0001h, resume.
// - polarity one: output starts high, low at match, high at reload.
// - polarity zero: output starts low, high at match, low at reload.
// - pwm modes: written start count affects first pass only.
// - dual pwm drives second output, inverse of primary output.
// - dual pwm delays each rising edge on both outputs by 0-128 clocks.
// - dual pwm turns shared input pin into complementary output automatically.
// - prescaler divides system clock by 1 to 128 where used.
// - 16-bit up counter wraps FFFFh to 0000h without reload.
module timer_pwm_comparator_counter (
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  input  wire tmr_pkg::wb_req_s   wb_req_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               cmp_out_i,
  input  wire logic               tin_i,
  output tmr_pkg::tmr_pins_s      pins_o,
  output logic                    tin_sync_o,
  output logic                    reload_o
);
  import tmr_pkg::*;

  logic [7:0]  ctrl_r,   ctrl_nxt;
  logic [1:0]  ctrl2_r,  ctrl2_nxt;
  logic [15:0] count_r,  count_nxt;
  logic [15:0] match_r,  match_nxt;
  logic [15:0] reload_r, reload_nxt;
  logic [7:0]  db_r,     db_nxt;
  logic        tout_r,   tout_nxt;
  logic        ack_r,    ack_nxt;
  logic [31:0] rdat_r,   rdat_nxt;
  logic        cmp_s1_r, cmp_s2_r, cmp_s3_r;
  logic        tin_s1_r, tin_s2_r;
  logic        en_d_r;

  tmr_mode_e   mode;
  logic        en;
  logic        pol;
  logic        tick;
  logic        pre_tick;
  logic        cmp_edge;
  logic        at_reload;
  logic        at_match;
  logic        wr;
  logic        rd;
  logic        pwm_mode;
  logic        db_pri;
  logic        db_cmp;

  // byte-enable merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) r[7:0]  = dat[7:0];
    if (sel[1]) r[15:8] = dat[15:8];
    return r;
  endfunction

  // mode decode: two control bits plus bit 0 of the second control
  always_comb begin
    en  = ctrl_r[`CTRL_EN_BIT];
    pol = ctrl_r[`CTRL_POL_BIT];
    case ({ctrl2_r[`CTRL2_MHI_BIT], ctrl_r[`CTRL_MODE_LSB +: 2]})
      3'h1:    mode = MODE_CMP_COUNT;
      3'h2:    mode = MODE_PWM_SINGLE;
      3'h6:    mode = MODE_PWM_DUAL;
      default: mode = MODE_OFF;
    endcase
  end

  assign pwm_mode = (mode == MODE_PWM_SINGLE) || (mode == MODE_PWM_DUAL);

  // both off-chip levels pass two flops before use
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      cmp_s3_r <= 1'b0;
      tin_s1_r <= 1'b0;
      tin_s2_r <= 1'b0;
      en_d_r   <= 1'b0;
    end else begin
      cmp_s1_r <= cmp_out_i;
      cmp_s2_r <= cmp_s1_r;
      cmp_s3_r <= cmp_s2_r;
      tin_s1_r <= tin_i;
      tin_s2_r <= tin_s1_r;
      en_d_r   <= en;
    end
  end

  // edge select: polarity 0 rising, 1 falling
  assign cmp_edge = pol ? (cmp_s3_r & ~cmp_s2_r)
                        : (~cmp_s3_r & cmp_s2_r);

  tmr_prescaler #(
    .SEL_W (3)
  ) u_pre (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .run_i      (en && pwm_mode),
    .sel_i      (ctrl_r[`CTRL_PRE_LSB +: 3]),
    .tick_o     (pre_tick)
  );

  // comparator mode ignores the prescaler entirely
  always_comb begin
    tick = 1'b0;
    if (en) begin
      case (mode)
        MODE_CMP_COUNT:  tick = cmp_edge;
        MODE_PWM_SINGLE: tick = pre_tick;
        MODE_PWM_DUAL:   tick = pre_tick;
        default:         tick = 1'b0;
      endcase
    end
  end

  assign at_reload = tick && (count_r == reload_r);
  assign at_match  = tick && pwm_mode && (count_r == match_r);
  assign wr = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !ack_r;
  assign rd = wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !ack_r;

  // register writes, count advance and output level
  always_comb begin
    ctrl_nxt   = ctrl_r;
    ctrl2_nxt  = ctrl2_r;
    count_nxt  = count_r;
    match_nxt  = match_r;
    reload_nxt = reload_r;
    db_nxt     = db_r;
    tout_nxt   = tout_r;
    if (!en) begin
      // idle level follows the polarity bit in every mode
      tout_nxt = pol;
    end else if (!en_d_r && pwm_mode) begin
      tout_nxt = pol;
    end
    if (at_reload) begin
      count_nxt = `COUNT_RELOAD;
      if (mode == MODE_CMP_COUNT) begin
        if (ctrl2_r[`CTRL2_OEN_BIT]) tout_nxt = ~tout_r;
      end else begin
        tout_nxt = pol;
      end
    end else if (tick) begin
      count_nxt = count_r + 16'h0001;
      if (at_match) tout_nxt = ~pol;
    end
    if (wr) begin
      case (wb_req_i.adr)
        `OFS_CTRL:
          if (wb_req_i.sel[0]) ctrl_nxt = wb_req_i.dat[7:0];
        `OFS_CTRL2:
          if (wb_req_i.sel[0]) ctrl2_nxt = wb_req_i.dat[1:0];
        `OFS_COUNT:  count_nxt  = merge16(count_r, wb_req_i.dat,
                                          wb_req_i.sel);
        `OFS_MATCH:  match_nxt  = merge16(match_r, wb_req_i.dat,
                                          wb_req_i.sel);
        `OFS_RELOAD: reload_nxt = merge16(reload_r, wb_req_i.dat,
                                          wb_req_i.sel);
        `OFS_DEADBAND:
          if (wb_req_i.sel[0]) begin
            db_nxt = (wb_req_i.dat[7:0] > `DB_MAX) ? `DB_MAX
                                                    : wb_req_i.dat[7:0];
          end
        default: ;
      endcase
    end
  end

  // read mux and single-cycle ack; unmapped reads return zero
  always_comb begin
    ack_nxt  = (wb_req_i.cyc && wb_req_i.stb && !ack_r);
    rdat_nxt = rdat_r;
    if (rd) begin
      case (wb_req_i.adr)
        `OFS_CTRL:     rdat_nxt = {24'h0, ctrl_r};
        `OFS_CTRL2:    rdat_nxt = {30'h0, ctrl2_r};
        `OFS_COUNT:    rdat_nxt = {16'h0, count_r};
        `OFS_MATCH:    rdat_nxt = {16'h0, match_r};
        `OFS_RELOAD:   rdat_nxt = {16'h0, reload_r};
        `OFS_DEADBAND: rdat_nxt = {24'h0, db_r};
        default:       rdat_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl_r   <= 8'h00;
      ctrl2_r  <= 2'h0;
      count_r  <= `COUNT_RST;
      match_r  <= 16'h0000;
      reload_r <= `RELOAD_RST;
      db_r     <= 8'h00;
      tout_r   <= 1'b0;
      ack_r    <= 1'b0;
      rdat_r   <= 32'h0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      ctrl2_r  <= ctrl2_nxt;
      count_r  <= count_nxt;
      match_r  <= match_nxt;
      reload_r <= reload_nxt;
      db_r     <= db_nxt;
      tout_r   <= tout_nxt;
      ack_r    <= ack_nxt;
      rdat_r   <= rdat_nxt;
    end
  end

  // dead band on both rising edges; dual pair never overlaps high
  tmr_deadband u_db_pri (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .lvl_i      (tout_r),
    .db_i       (db_r),
    .lvl_o      (db_pri)
  );

  tmr_deadband u_db_cmp (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .lvl_i      (~tout_r),
    .db_i       (db_r),
    .lvl_o      (db_cmp)
  );

  // pin drive; shared input pin flips to complement in dual mode
  always_comb begin
    pins_o.out     = (mode == MODE_PWM_DUAL) ? db_pri : tout_r;
    pins_o.out_oe  = ctrl2_r[`CTRL2_OEN_BIT] || (en && pwm_mode);
    pins_o.comp    = (mode == MODE_PWM_DUAL) ? db_cmp : 1'b0;
    pins_o.comp_oe = (mode == MODE_PWM_DUAL);
  end

  assign tin_sync_o = tin_s2_r;
  assign reload_o   = at_reload;
  assign wb_dat_o   = rdat_r;
  assign wb_ack_o   = ack_r;
endmodule // timer_pwm_comparator_counter

// ### tb/tmr_props.sv
// checker: bus shadow of settings and timer pin relations
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_props (
  input wire logic               core_clk_i,
  input wire logic               rst_n_i,
  input wire tmr_pkg::wb_req_s   wb_req_i,
  input wire logic               wb_ack_o,
  input wire logic               cmp_out_i,
  input wire tmr_pkg::tmr_pins_s pins_o,
  input wire logic               reload_o
);
  import tmr_pkg::*;
  logic [7:0] ctl_r, db_r;
  logic [1:0] c2_r;
  logic [8:0] gap_r;
  logic       wr, en, pol, dual, sngl, cmpm;
  // decoded view of the shadowed settings
  assign wr   = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~wb_ack_o;
  assign en   = ctl_r[`CTRL_EN_BIT];
  assign pol  = ctl_r[`CTRL_POL_BIT];
  assign dual = {c2_r[0], ctl_r[1:0]} == 3'h6;
  assign sngl = {c2_r[0], ctl_r[1:0]} == 3'h2;
  assign cmpm = {c2_r[0], ctl_r[1:0]} == 3'h1;
  // shadow follows writes on the same edge as the slave
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctl_r <= 8'h00;
      c2_r  <= 2'h0;
      db_r  <= 8'h00;
    end else if (wr) begin
      if (wb_req_i.adr == `OFS_CTRL) ctl_r <= wb_req_i.dat[7:0];
      if (wb_req_i.adr == `OFS_CTRL2) c2_r <= wb_req_i.dat[1:0];
      if (wb_req_i.adr == `OFS_DEADBAND) db_r <= wb_req_i.dat[7:0];
    end
  end
  // cycles since comp fell; saturates so a long idle never aliases
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) gap_r <= 9'h1ff;
    else if (pins_o.comp) gap_r <= 9'h000;
    else gap_r <= gap_r + {8'h00, ~&gap_r};
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_excl;
    dual && $past(dual) |-> !(pins_o.out && pins_o.comp);
  endproperty
  a_excl: assert property (p_excl)
    else $error("both outputs high");
  property p_oe;
    dual == $past(dual) |-> pins_o.comp_oe == dual;
  endproperty
  a_oe: assert property (p_oe)
    else $error("comp enable wrong for mode");
  property p_lvl;
    sngl && en && reload_o |=> pins_o.out == $past(pol);
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("level after reload wrong");
  property p_tog;
    cmpm && en && c2_r[1] && reload_o |=> pins_o.out != $past(pins_o.out);
  endproperty
  a_tog: assert property (p_tog)
    else $error("output did not toggle");
  property p_idle;
    !en && !dual && $stable(ctl_r) |-> pins_o.out == pol;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle level wrong");
  property p_edge;
    cmpm && en && reload_o |->
      $past(cmp_out_i, 2) != pol && $past(cmp_out_i, 6) == pol;
  endproperty
  a_edge: assert property (p_edge)
    else $error("reload on wrong comparator edge");
  property p_gap;
    dual && $rose(pins_o.out) && gap_r <= 9'd128 |-> gap_r == {1'b0, db_r};
  endproperty
  a_gap: assert property (p_gap)
    else $error("dead band length wrong");
  property p_div;
    sngl && en && ctl_r[5:3] != 3'h0 && reload_o |=> !reload_o;
  endproperty
  a_div: assert property (p_div)
    else $error("reload faster than prescale");
  c_cmp: cover property (cmpm && reload_o);
  c_pwm: cover property (sngl && reload_o);
  c_db: cover property (dual && $rose(pins_o.out));
endmodule // tmr_props

// ### tb/tmr_cmp_model.sv
// comparator model: one clean pulse per request
`timescale 1ns/1ps
module tmr_cmp_model (
  input  wire logic core_clk_i,
  input  wire logic fire_i,
  output logic      cmp_o
);
  logic [2:0] ph_r = 3'h0;
  // four high, four low: edges stay under a quarter of the clock rate
  always_ff @(posedge core_clk_i) begin
    if (ph_r != 3'h0 || fire_i) ph_r <= ph_r + 3'h1;
  end
  assign cmp_o = ph_r != 3'h0 && ph_r <= 3'h4;
endmodule // tmr_cmp_model

// ### tb/timer_pwm_comparator_counter_test.sv
// testbench: comparator counting, pwm timing, dead band
`timescale 1ns/1ps
`include "tmr_consts.svh"
module timer_pwm_comparator_counter_test;
  import tmr_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        fire = 1'b0;
  logic        ack, rel, cmp;
  logic [31:0] rdat, rd;
  wb_req_s     req = '0;
  tmr_pins_s   pins;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc_n = 0;
  always #5 clk = ~clk;
  timer_pwm_comparator_counter timer_pwm_comparator_counter_i (
    .core_clk_i(clk), .rst_n_i(rst_n), .wb_req_i(req), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cmp_out_i(cmp), .tin_i(1'b0), .pins_o(pins),
    .tin_sync_o(), .reload_o(rel));
  tmr_cmp_model tmr_cmp_model_i (.core_clk_i(clk), .fire_i(fire),
    .cmp_o(cmp));
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk) req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    // ack and read data are taken at the rising edge, then released
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk(ack, 1'b1);
    rd = rdat;
    req <= '0;
  endtask
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge clk) fire <= 1'b1;
      @(posedge clk) fire <= 1'b0;
      repeat (9) @(posedge clk);
    end
  endtask
  task automatic wrel(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rel !== 1'b1 && n < 300);
  endtask
  task automatic flip(input logic p, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pins.out === p && n < 50);
  endtask
  task automatic t_cmp();
    wb(1'b1, `OFS_CTRL, 32'h79);
    @(negedge clk);
    chk(pins.out, 1'b1);
    wb(1'b1, `OFS_CTRL, 32'h39);      // prescale set but must be ignored
    wb(1'b1, `OFS_CTRL2, 32'h2);
    wb(1'b1, `OFS_COUNT, 32'h1);
    wb(1'b1, `OFS_RELOAD, 32'h3);
    wb(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, `OFS_CTRL, 32'hb9);
    pulse(2);
    wb(1'b0, `OFS_COUNT, 32'h0);
    chk(rd, 32'h3);
    pulse(1);
    wb(1'b0, `OFS_COUNT, 32'h0);
    chk(rd, 32'h1);
    chk(pins.out, 1'b1);
    wb(1'b1, `OFS_COUNT, 32'h2);
    pulse(3);
    wb(1'b0, `OFS_COUNT, 32'h0);
    chk(rd, 32'h2);
    chk(pins.out, 1'b0);
    wb(1'b1, `OFS_CTRL, 32'h39);
    $display("comparator test done");
  endtask
  task automatic t_pwm(input logic p);
    int n;
    wb(1'b1, `OFS_CTRL, {25'h0, p, 6'h0a});
    wb(1'b1, `OFS_CTRL2, 32'h0);
    wb(1'b1, `OFS_MATCH, 32'h3);
    wb(1'b1, `OFS_RELOAD, 32'h5);
    wb(1'b1, `OFS_COUNT, 32'h4);
    wb(1'b1, `OFS_CTRL, {25'h1, p, 6'h0a});
    chk(pins.out_oe, 1'b1);
    wrel(n);
    chk(n <= 6, 1'b1);
    flip(p, n);
    chk(n, 7);
    wrel(n);
    wrel(n);
    chk(n, 10);
    wb(1'b1, `OFS_CTRL, {25'h0, p, 6'h0a});
    $display("pwm test done");
  endtask
  task automatic t_dual();
    int n;
    wb(1'b1, `OFS_CTRL2, 32'h1);
    for (int d = 2; d >= 0; d -= 2) begin
      wb(1'b1, `OFS_CTRL, 32'h0a);
      wb(1'b1, `OFS_DEADBAND, d);
      wb(1'b1, `OFS_CTRL, 32'h8a);
      chk(pins.comp_oe, 1'b1);
      wrel(n);
      flip(1'b0, n);
      chk(n, 7 + d);
      chk(pins.comp, 1'b0);
    end
    wb(1'b1, `OFS_CTRL2, 32'h0);
    chk(pins.comp_oe, 1'b0);
    $display("dual pwm test done");
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_cmp();
    t_pwm(1'b0);
    t_pwm(1'b1);
    t_dual();
    results();
  end
endmodule // timer_pwm_comparator_counter_test
bind timer_pwm_comparator_counter tmr_props tmr_props_i (
  .core_clk_i, .rst_n_i, .wb_req_i, .wb_ack_o, .cmp_out_i, .pins_o,
  .reload_o);
